// file: src/sdf_crc.sv
// Purpose: Byte-serial CRC-16 in bit-stream order
// Assumes: Bytes go LSB first, so the reflected generator is used
// Notes: next_o is the value after feeding byte_i this cycle
`timescale 1ns/1ps
`include "sdf_regs.svh"
module sdf_crc
	import sdf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic feed_i,
	input wire logic start_i,
	input wire sdf_byte_t byte_i,
	output logic [15:0] crc_o,
	output logic [15:0] next_o
);
	logic [15:0] stage [9];
	assign stage[0] = (start_i ? `SDF_CRC_INIT : crc_o) ^ {8'h00, byte_i};
	genvar b;
	generate
		for (b = 0; b < 8; b++)
		begin : g_bit
			assign stage[b+1] = stage[b][0] ? ((stage[b] >> 1) ^ `SDF_CRC_POLY)
				: (stage[b] >> 1);
		end
	endgenerate
	assign next_o = stage[8];
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			crc_o <= `SDF_CRC_INIT;
		else if (feed_i)
			crc_o <= next_o;
	end
endmodule

// file: src/sdf_fifo.sv
// Purpose: Forwarding buffer of the chain byte stream
// Assumes: One clock, synchronous active-low reset
// Notes: Count is exported so the feeder can register its ready
`timescale 1ns/1ps
module sdf_fifo
	import sdf_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int CW = 4
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [CW-1:0] count_o
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [$clog2(DEPTH)-1:0] wptr;
	logic [$clog2(DEPTH)-1:0] rptr;
	logic push;
	logic pop;
	assign in_ready_o = (count_o != CW'(DEPTH));
	assign out_valid_o = (count_o != '0);
	assign out_data_o = mem[rptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wptr <= '0;
			rptr <= '0;
			count_o <= '0;
		end
		else
		begin
			if (push)
				wptr <= wptr + 1'b1;
			if (pop)
				rptr <= rptr + 1'b1;
			if (push && !pop)
				count_o <= count_o + 1'b1;
			else if (pop && !push)
				count_o <= count_o - 1'b1;
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wptr] <= in_data_i;
	end
endmodule

// file: src/sdf_frame_rw.sv
// Purpose: Single-device read and write frame interpreter on a daisy chain
// Assumes: Byte stream in, every byte forwarded; register port answers one cycle later
// Notes: Frame intake pauses while a command executes; forwarding keeps draining
// How it works
// - Execute a command only when the frame CRC check passes.
// - Whole frame including CRC bytes must leave a zero remainder.
// - A read answers with one frame carrying exactly the requested bytes.
// - Read initialization byte has payload size zero.
// - All frames are forwarded; only the addressed device answers reads.
// - Answer uses the standard response layout with register data.
// - A write updates one to eight consecutive registers.
// - Write payload size is register count minus one.
// - Only the addressed device executes a write; others only forward.
// - Single read initialization byte is the fixed read code.
// - Single write uses request kind one, code grows with byte count.
// - Read data byte is byte count minus one.
// - Order: init, device address, register address, data, two CRC bytes.
// - CRC generator x16+x15+x2+1, preset all ones.
// - CRC mismatch drops the frame, flags an error, still forwards.
// - Bytes go LSB first; CRC runs in that bit order.
`timescale 1ns/1ps
`include "sdf_regs.svh"
module sdf_frame_rw
	import sdf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire sdf_byte_t dev_addr_i,
	input wire sdf_byte_t rx_byte_i,
	input wire logic rx_valid_i,
	output logic rx_ready_o,
	output sdf_byte_t fwd_byte_o,
	output logic fwd_valid_o,
	input wire logic fwd_ready_i,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [15:0] reg_addr_o,
	output sdf_byte_t reg_wdata_o,
	input wire sdf_byte_t reg_rdata_i,
	output sdf_byte_t resp_byte_o,
	output logic resp_valid_o,
	input wire logic resp_ready_i,
	output logic crc_err_o
);
	sdf_state_t state;
	logic rx_take;
	logic fifo_in_ready;
	logic [`SDF_FIFO_CW-1:0] fifo_cnt;
	logic [7:0] rx_idx;
	logic [7:0] rx_last;
	logic [7:0] next_last;
	logic [7:0] data_bytes;
	logic [15:0] rx_crc;
	logic [15:0] rx_crc_next;
	logic frame_end;
	logic crc_zero;
	sdf_byte_t init_q;
	sdf_byte_t dev_q;
	logic [15:0] start_q;
	logic [6:0] rd_len;
	logic [2:0] wlast;
	logic [2:0] widx;
	sdf_byte_t wbuf [8];
	logic exec_rd;
	logic exec_wr;
	logic idle_next;
	logic [1:0] hidx;
	logic [6:0] rsent;
	sdf_byte_t hdr_byte;
	logic tx_hs;
	logic tx_feed;
	logic [15:0] tx_crc;
	logic [2:0] cur_req;

	// Registered ready keeps one slot spare, so the buffer can never overflow
	assign rx_take = rx_valid_i && rx_ready_o;
	sdf_fifo #(
		.WIDTH(8),
		.DEPTH(`SDF_FIFO_DEPTH),
		.CW(`SDF_FIFO_CW)
	) u_fwd (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(rx_take),
		.in_ready_o(fifo_in_ready),
		.in_data_i(rx_byte_i),
		.out_valid_o(fwd_valid_o),
		.out_ready_i(fwd_ready_i),
		.out_data_o(fwd_byte_o),
		.count_o(fifo_cnt)
	);

	sdf_crc u_rx_crc (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.feed_i(rx_take),
		.start_i(rx_idx == `SDF_IDX_INIT),
		.byte_i(rx_byte_i),
		.crc_o(rx_crc),
		.next_o(rx_crc_next)
	);

	// Frame length from the initialization byte; other frame kinds pass through
	assign cur_req = rx_byte_i[`SDF_REQ_HI:`SDF_REQ_LO];
	always_comb
	begin
		data_bytes = 8'h01;
		next_last = 8'h00;
		if (!rx_byte_i[`SDF_FRAME_BIT])
			data_bytes = {1'b0, rx_byte_i[6:0]} + 8'h01;
		else if (cur_req[0])
			data_bytes = {5'h00, rx_byte_i[`SDF_DS_HI:`SDF_DS_LO]} + 8'h01;
		next_last = `SDF_HDR_BYTES + data_bytes + `SDF_CRC_BYTES;
		if (rx_byte_i[`SDF_FRAME_BIT] && cur_req[2:1] != 2'h0)
			next_last = next_last - 8'h01;
	end

	assign frame_end = rx_take && (rx_idx != `SDF_IDX_INIT) && (rx_idx == rx_last);
	assign crc_zero = (rx_crc_next == `SDF_CRC_GOOD);
	assign exec_rd = frame_end && crc_zero && (dev_q == dev_addr_i)
		&& (init_q == `SDF_INIT_SREAD)
		&& (init_q[`SDF_DS_HI:`SDF_DS_LO] == `SDF_DS_READ);
	assign exec_wr = frame_end && crc_zero && (dev_q == dev_addr_i)
		&& init_q[`SDF_FRAME_BIT]
		&& (init_q[`SDF_REQ_HI:`SDF_REQ_LO] == `SDF_REQ_SWRITE);

	// Frame field capture
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rx_idx <= `SDF_IDX_INIT;
			rx_last <= 8'h00;
			init_q <= 8'h00;
			dev_q <= 8'h00;
			start_q <= 16'h0000;
			rd_len <= 7'h00;
		end
		else if (rx_take)
		begin
			rx_idx <= frame_end ? `SDF_IDX_INIT : rx_idx + 8'h01;
			if (rx_idx == `SDF_IDX_INIT)
			begin
				init_q <= rx_byte_i;
				rx_last <= next_last;
			end
			if (rx_idx == `SDF_IDX_DEV)
				dev_q <= rx_byte_i;
			if (rx_idx == `SDF_IDX_RAH)
				start_q[15:8] <= rx_byte_i;
			if (rx_idx == `SDF_IDX_RAL)
				start_q[7:0] <= rx_byte_i;
			if (rx_idx == `SDF_IDX_DATA)
				rd_len <= rx_byte_i[6:0];
		end
	end

	// Write data holding, eight bytes at most
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_wbuf
			always_ff @(posedge clk_i)
			begin
				if (!rst_n_i)
					wbuf[g] <= 8'h00;
				else if (rx_take && rx_idx == `SDF_IDX_DATA + 8'(g))
					wbuf[g] <= rx_byte_i;
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			crc_err_o <= 1'b0;
		else
			crc_err_o <= frame_end && !crc_zero;
	end

	// Sequencer
	assign tx_hs = resp_valid_o && resp_ready_i;
	assign idle_next = (state == ST_IDLE && !exec_rd && !exec_wr)
		|| (state == ST_WR && widx == wlast)
		|| (state == ST_RCRCH && tx_hs);
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state <= ST_IDLE;
			wlast <= 3'h0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (exec_rd)
						state <= ST_RHDR;
					else if (exec_wr)
					begin
						state <= ST_WR;
						wlast <= init_q[`SDF_DS_HI:`SDF_DS_LO];
					end
				end
				ST_WR:
					if (widx == wlast)
						state <= ST_IDLE;
				ST_RHDR:
					if (tx_hs && hidx == `SDF_HDR_LAST)
						state <= ST_RREQ;
				ST_RREQ:
					state <= ST_RACC;
				ST_RACC:
					state <= ST_RCAP;
				ST_RCAP:
					state <= ST_RDATA;
				ST_RDATA:
					if (tx_hs)
						state <= (rsent == rd_len) ? ST_RCRCL : ST_RREQ;
				ST_RCRCL:
					if (tx_hs)
						state <= ST_RCRCH;
				ST_RCRCH:
					if (tx_hs)
						state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rx_ready_o <= 1'b0;
		else
			rx_ready_o <= idle_next && (fifo_cnt <= `SDF_FIFO_ROOM);
	end

	// Register access port
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			reg_wr_o <= 1'b0;
			reg_rd_o <= 1'b0;
			reg_addr_o <= 16'h0000;
			reg_wdata_o <= 8'h00;
			widx <= 3'h0;
		end
		else
		begin
			reg_wr_o <= (state == ST_WR);
			reg_rd_o <= (state == ST_RREQ);
			if (state == ST_WR)
			begin
				reg_addr_o <= start_q + {13'h0000, widx};
				reg_wdata_o <= wbuf[widx];
				widx <= widx + 3'h1;
			end
			else
				widx <= 3'h0;
			if (state == ST_RREQ)
				reg_addr_o <= start_q + {9'h000, rsent};
		end
	end

	// Response frame: length code, own address, start address, data, CRC
	always_comb
	begin
		case (hidx)
			2'h0: hdr_byte = {1'b0, rd_len};
			2'h1: hdr_byte = dev_addr_i;
			2'h2: hdr_byte = start_q[15:8];
			default: hdr_byte = start_q[7:0];
		endcase
	end

	assign tx_feed = tx_hs && (state == ST_RHDR || state == ST_RDATA);
	sdf_crc u_tx_crc (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.feed_i(tx_feed),
		.start_i(state == ST_RHDR && hidx == 2'h0),
		.byte_i(resp_byte_o),
		.crc_o(tx_crc),
		.next_o()
	);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			resp_byte_o <= 8'h00;
			resp_valid_o <= 1'b0;
			hidx <= 2'h0;
			rsent <= 7'h00;
		end
		else
		begin
			case (state)
				ST_RHDR:
				begin
					if (!resp_valid_o)
					begin
						resp_byte_o <= hdr_byte;
						resp_valid_o <= 1'b1;
					end
					else if (resp_ready_i)
					begin
						resp_valid_o <= 1'b0;
						hidx <= hidx + 2'h1;
					end
				end
				ST_RCAP:
				begin
					resp_byte_o <= reg_rdata_i;
					resp_valid_o <= 1'b1;
				end
				ST_RDATA:
				begin
					if (resp_ready_i)
					begin
						resp_valid_o <= 1'b0;
						rsent <= rsent + 7'h01;
					end
				end
				ST_RCRCL, ST_RCRCH:
				begin
					// Low byte first keeps the receiver's residue at zero
					if (!resp_valid_o)
					begin
						resp_byte_o <= (state == ST_RCRCL) ? tx_crc[7:0] : tx_crc[15:8];
						resp_valid_o <= 1'b1;
					end
					else if (resp_ready_i)
						resp_valid_o <= 1'b0;
				end
				ST_IDLE:
				begin
					hidx <= 2'h0;
					rsent <= 7'h00;
				end
				default:
				begin
				end
			endcase
		end
	end

	// Checking helpers
	logic [7:0] wr_burst;
	logic [7:0] dcount;
	logic [15:0] last_rd;
	logic rd_seen;
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_burst <= 8'h00;
			dcount <= 8'h00;
			last_rd <= 16'h0000;
			rd_seen <= 1'b0;
		end
		else
		begin
			if (reg_wr_o)
				wr_burst <= wr_burst + 8'h01;
			else if (state == ST_IDLE)
				wr_burst <= 8'h00;
			if (state == ST_RHDR)
				dcount <= 8'h00;
			else if (state == ST_RDATA && tx_hs)
				dcount <= dcount + 8'h01;
			if (reg_rd_o)
			begin
				last_rd <= reg_addr_o;
				rd_seen <= 1'b1;
			end
			else if (state == ST_IDLE)
				rd_seen <= 1'b0;
		end
	end

	crc_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(frame_end && !crc_zero) |=> (!reg_wr_o && !reg_rd_o && state == ST_IDLE)[*3])
		else $error("command ran on a bad CRC");
	crc_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		crc_err_o |-> $past(frame_end) && $past(rx_crc_next) != `SDF_CRC_GOOD)
		else $error("CRC error flag without a bad residue");
	forward_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rx_take |=> fwd_valid_o)
		else $error("received byte not offered for forwarding");
	no_overflow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rx_ready_o |-> fifo_in_ready)
		else $error("intake ready while buffer full");
	addr_match_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(reg_wr_o) |-> dev_q == dev_addr_i
		&& init_q[`SDF_REQ_HI:`SDF_REQ_LO] == `SDF_REQ_SWRITE)
		else $error("write by a device that was not addressed");
	wr_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(reg_wr_o) |-> wr_burst == {5'h00, wlast} + 8'h01)
		else $error("write burst length differs from payload size");
	wr_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(reg_wr_o && $past(reg_wr_o)) |-> reg_addr_o == $past(reg_addr_o) + 16'h0001)
		else $error("write address did not step by one");
	rd_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(reg_rd_o && rd_seen) |-> reg_addr_o == last_rd + 16'h0001)
		else $error("read address did not step by one");
	resp_len_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state == ST_RCRCL && $past(state) == ST_RDATA) |-> dcount == {1'b0, rd_len} + 8'h01)
		else $error("response payload length wrong");
	resp_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state == ST_IDLE ##1 state == ST_RHDR) |-> init_q == `SDF_INIT_SREAD
		&& dev_q == dev_addr_i)
		else $error("response started for a non single-read frame");
	rd_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reg_rd_o |=> ##1 (resp_valid_o && resp_byte_o == $past(reg_rdata_i)))
		else $error("response byte is not the register data");

	write_seen_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(reg_wr_o) && wr_burst == 8'h08);
	read_done_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		state == ST_RCRCH && tx_hs);
	crc_bad_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		crc_err_o);
	stall_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		rx_valid_i && !rx_ready_o && fifo_cnt == 4'h7);
endmodule

// file: src/sdf_pkg.sv
// Purpose: Types of the single-device frame interpreter
// Assumes: Nothing beyond the constants header
// Notes: One-hot sequencer states
package sdf_pkg;
	typedef logic [7:0] sdf_byte_t;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_WR = 9'h002,
		ST_RHDR = 9'h004,
		ST_RREQ = 9'h008,
		ST_RACC = 9'h010,
		ST_RCAP = 9'h020,
		ST_RDATA = 9'h040,
		ST_RCRCL = 9'h080,
		ST_RCRCH = 9'h100
	} sdf_state_t;
endpackage

// file: src/sdf_regs.svh
// Purpose: Named constants of the single-device frame interpreter
// Assumes: Byte-wide chain stream, CRC kept in bit-stream (LSB first) order
// Notes: Definitions only
`ifndef SDF_REGS_SVH
`define SDF_REGS_SVH
`define SDF_CRC_INIT 16'hFFFF
`define SDF_CRC_POLY 16'hA001
`define SDF_CRC_GOOD 16'h0000
`define SDF_INIT_SREAD 8'h80
`define SDF_REQ_SREAD 3'h0
`define SDF_REQ_SWRITE 3'h1
`define SDF_FRAME_BIT 7
`define SDF_REQ_HI 6
`define SDF_REQ_LO 4
`define SDF_DS_HI 2
`define SDF_DS_LO 0
`define SDF_DS_READ 3'h0
`define SDF_IDX_INIT 8'h00
`define SDF_IDX_DEV 8'h01
`define SDF_IDX_RAH 8'h02
`define SDF_IDX_RAL 8'h03
`define SDF_IDX_DATA 8'h04
`define SDF_HDR_BYTES 8'h03
`define SDF_CRC_BYTES 8'h02
`define SDF_FIFO_DEPTH 8
`define SDF_FIFO_CW 4
`define SDF_FIFO_ROOM 4'h6
`define SDF_HDR_LAST 2'h3
`endif

// file: tb/sdf_reg_model.sv
// Purpose: Register space behind the frame interpreter
// Assumes: Read data valid the cycle after the read strobe
// Notes: Only the low address byte decodes, so the space aliases
`timescale 1ns/1ps
module sdf_reg_model
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [256];
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < 256; i++)
				mem[i] <= 8'(i) ^ 8'h5A;
		end
		else if (wr_i)
			mem[addr_i[7:0]] <= wdata_i;
	end
	// Toggles when idle so stale data never passes as fresh
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rdata_o <= 8'h00;
		else if (rd_i)
			rdata_o <= mem[addr_i[7:0]];
		else
			rdata_o <= ~rdata_o;
	end
endmodule

// file: tb/tb_top.sv
// Purpose: Self-checking bench of the frame interpreter
// Assumes: This device sits at chain address 02
// Notes: Forward and response sinks stall on a fixed pattern
`timescale 1ns/1ps
module tb_top;
	import sdf_pkg::*;
	logic clk_i = 0;
	logic rst_n_i = 0;
	logic rx_valid_i = 0;
	logic fwd_ready_i = 0;
	logic resp_ready_i = 0;
	logic [7:0] dev_addr_i = 8'h02;
	logic [7:0] rx_byte_i = 8'h00;
	logic [7:0] rdata, fwd_byte, reg_wdata, resp_byte;
	logic rx_ready, fwd_valid, reg_wr, reg_rd, resp_valid, crc_err;
	logic [15:0] reg_addr;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	int nerr = 0;
	logic [7:0] fq[$], rq[$], wd[$];
	logic [15:0] wa[$];

	initial forever #50 clk_i = ~clk_i;

	sdf_frame_rw sdf_frame_rw_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .dev_addr_i(dev_addr_i),
		.rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready),
		.fwd_byte_o(fwd_byte), .fwd_valid_o(fwd_valid), .fwd_ready_i(fwd_ready_i),
		.reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
		.reg_wdata_o(reg_wdata), .reg_rdata_i(rdata), .resp_byte_o(resp_byte),
		.resp_valid_o(resp_valid), .resp_ready_i(resp_ready_i), .crc_err_o(crc_err));

	sdf_reg_model sdf_reg_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_i(reg_rd),
		.wr_i(reg_wr), .addr_i(reg_addr), .wdata_i(reg_wdata), .rdata_o(rdata));

	// Sinks stall so the buffer fills and valid must hold
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		fwd_ready_i <= (cyc[1:0] != 2'h0);
		resp_ready_i <= cyc[2];
		if (fwd_valid && fwd_ready_i)
			fq.push_back(fwd_byte);
		if (resp_valid && resp_ready_i)
			rq.push_back(resp_byte);
		if (reg_wr)
		begin
			wa.push_back(reg_addr);
			wd.push_back(reg_wdata);
		end
		if (crc_err)
			nerr++;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			$display("BAD %0t got %h exp %h", $time, g, e);
			err_total++;
		end
	endtask

	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction

	task automatic send(input logic [7:0] f[$], input logic bad);
		logic [15:0] c;
		c = crc16(f) ^ {15'h0000, bad};
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		fq.delete();
		rq.delete();
		wa.delete();
		wd.delete();
		nerr = 0;
		foreach (f[i])
		begin
			rx_byte_i <= f[i];
			rx_valid_i <= 1'b1;
			do @(posedge clk_i); while (rx_ready !== 1'b1);
		end
		rx_valid_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		repeat (300) if (fq.size() < f.size()) @(posedge clk_i);
		chk(fq.size(), f.size());
		foreach (f[i])
			if (i < fq.size()) chk(fq[i], f[i]);
		chk(nerr, {31'h0, bad});
	endtask

	task automatic wr_test(input int n, input logic [7:0] dev, input logic bad,
		input logic [7:0] d0);
		logic [7:0] f[$];
		f = {8'h90 + 8'(n - 1), dev, 8'h03, 8'h00};
		for (int i = 0; i < n; i++)
			f.push_back(d0 + 8'(i));
		send(f, bad);
		if (dev != 8'h02 || bad)
			chk(wa.size(), 0);
		else
		begin
			chk(wa.size(), n);
			foreach (wa[i])
			begin
				chk(wa[i], 16'h0300 + 16'(i));
				chk(wd[i], d0 + 8'(i));
			end
		end
	endtask

	task automatic rd_test(input logic [15:0] a, input logic [7:0] cnt, input logic [7:0] dev);
		logic [7:0] f[$];
		logic [7:0] x;
		int len;
		len = (dev == 8'h02) ? int'(cnt) + 7 : 0;
		f = {8'h80, dev, a[15:8], a[7:0], cnt};
		send(f, 1'b0);
		repeat (2000) if (rq.size() < len) @(posedge clk_i);
		repeat (20) @(posedge clk_i);
		chk(rq.size(), len);
		if (len > 0 && rq.size() == len)
		begin
			chk(rq[0], cnt);
			chk(rq[1], dev);
			chk({rq[2], rq[3]}, a);
			for (int i = 0; i <= int'(cnt); i++)
			begin
				x = a[7:0] + 8'(i);
				chk(rq[4 + i], (x < 8'h08) ? 8'hA0 + x : x ^ 8'h5A);
			end
			chk(crc16(rq), 16'h0000);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(crc16({8'h80, 8'h02, 8'h05, 8'h68, 8'h1F}), 16'h6F5A);
		chk(crc16({8'h93, 8'h02, 8'h03, 8'h00, 8'h02, 8'hB7, 8'h78, 8'hBC}), 16'hAEB8);
		for (int n = 1; n <= 8; n++)
			wr_test(n, 8'h02, 1'b0, 8'hA0);
		wr_test(4, 8'h02, 1'b1, 8'h11);
		wr_test(4, 8'h03, 1'b0, 8'h22);
		rd_test(16'h0568, 8'h1F, 8'h02);
		rd_test(16'h0568, 8'h7F, 8'h02);
		rd_test(16'h0300, 8'h00, 8'h02);
		rd_test(16'h0568, 8'h1F, 8'h03);
		end_of_test();
	end

	// Whole run needs a few thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		end_of_test();
	end
endmodule
